//--- dtc_pkg.sv
// Constants shared by the dual timer and external interrupt control block.
// Assumes a single core clock and an APB master with 32-bit data.
// Functional notes
// - Run bit 4 of the control register starts and stops timer zero.
// - Interrupt one flag sets on selected edge/level; vectoring clears edge mode; level tracks pin.
// - Interrupt one type bit 2 selects falling edge when set, low level when clear.
// - Interrupt zero flag bit 1 sets on selected edge/level; same clearing as interrupt one.
// - Interrupt zero type bit 0 selects falling edge when set, low level when clear.
// - Mode bit 7 gates timer one by interrupt one pin high plus run bit.
// - Mode bit 3 gates timer zero by interrupt zero pin high plus run bit.
// - Mode bit 6 makes timer one count falling edges of its input pin.
// - Mode bit 2 makes timer zero count falling edges of its input pin.
// - Mode field bits 5:4 for timer one, 1:0 for timer zero.
// - Mode 00 is thirteen bits, the low byte a five-bit prescaler.
// - Mode 01 is a sixteen-bit counter without prescaling.
// - Mode 10 counts the low byte and reloads it from the high byte.
// - Timer zero mode 11 splits bytes; high byte runs under timer one run bit.
package dtc_pkg;
   // Printed offsets are indices; the byte address is four times the index.
   localparam logic [7:0] IDX_CTRL = 8'h88;
   localparam logic [7:0] IDX_MODE = 8'h89;
   localparam logic [7:0] IDX_TL0 = 8'h8A;
   localparam logic [7:0] IDX_TL1 = 8'h8B;
   localparam logic [7:0] IDX_TH0 = 8'h8C;
   localparam logic [7:0] IDX_TH1 = 8'h8D;
   localparam logic [7:0] IDX_STAT = 8'h40;
   localparam logic [7:0] IDX_CLR = 8'h41;
   localparam logic [7:0] IDX_EN = 8'h42;
   // Control register fields.
   localparam int CTRL_TYPE0 = 0;
   localparam int CTRL_FLAG0 = 1;
   localparam int CTRL_TYPE1 = 2;
   localparam int CTRL_FLAG1 = 3;
   localparam int CTRL_RUN0 = 4;
   localparam int CTRL_OVF0 = 5;
   localparam int CTRL_RUN1 = 6;
   localparam int CTRL_OVF1 = 7;
   localparam logic [7:0] CTRL_WMASK = 8'h55;
   // Mode register fields.
   localparam int MODE_GATE1 = 7;
   localparam int MODE_SRC1 = 6;
   localparam int MODE_M1_HI = 5;
   localparam int MODE_M1_LO = 4;
   localparam int MODE_GATE0 = 3;
   localparam int MODE_SRC0 = 2;
   localparam int MODE_M0_HI = 1;
   localparam int MODE_M0_LO = 0;
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // Status bits: timer zero overflow, timer one overflow, interrupt zero, interrupt one.
   localparam int STAT_OVF0 = 0;
   localparam int STAT_OVF1 = 1;
   localparam int STAT_EXT0 = 2;
   localparam int STAT_EXT1 = 3;
   localparam int STAT_W = 4;
   // Pin vector positions.
   localparam int PIN_EXT_IRQ_PIN_ZERO = 0;
   localparam int PIN_EXT_IRQ_PIN_ONE = 1;
   localparam int PIN_CNT0 = 2;
   localparam int PIN_CNT1 = 3;
   // Values after reset.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_STAT = 4'h0;
   localparam logic [3:0] RST_PINS = 4'hF;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [4:0] PRESCALE_TOP = 5'h1F;
endpackage

//--- dtc_top.sv
// Dual timer/counter with external interrupt detection behind an APB slave.
// Assumes pins are asynchronous to mclk and the acknowledges come from logic on mclk.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module dtc_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic count_input_zero,
   input wire logic count_input_one,
   input wire logic irq_ack_zero,
   input wire logic irq_ack_one,
   output logic ext_irq_zero_flag,
   output logic ext_irq_one_flag,
   output logic ovf_pulse_zero,
   output logic ovf_pulse_one,
   output logic irq
);
   function automatic logic [11:0] addr_of(input logic [7:0] idx);
      addr_of = {2'b00, idx, 2'b00};
   endfunction

   function automatic logic cnt_en(input logic run, input logic gate, input logic pin,
                                   input logic src, input logic fall);
      cnt_en = run & (~gate | pin) & (~src | fall);
   endfunction

   // Returns {overflow, high byte, low byte} after one step in the given mode.
   function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] tl,
                                        input logic [7:0] th, input logic inc);
      logic [15:0] w;
      w = {th, tl};
      step = {1'b0, th, tl};
      if (inc) begin
         case (m)
            dtc_pkg::MODE_13BIT: begin
               if (tl[4:0] == dtc_pkg::PRESCALE_TOP) begin
                  step = {th == 8'hFF, th + 8'h01, tl[7:5], 5'h00};
               end else begin
                  step = {1'b0, th, tl[7:5], tl[4:0] + 5'h01};
               end
            end
            dtc_pkg::MODE_16BIT: begin
               step = {w == 16'hFFFF, w + 16'h0001};
            end
            dtc_pkg::MODE_RELOAD: begin
               if (tl == 8'hFF) begin
                  step = {1'b1, th, th};
               end else begin
                  step = {1'b0, th, tl + 8'h01};
               end
            end
            default: begin
               step = {tl == 8'hFF, th, tl + 8'h01};
            end
         endcase
      end
   endfunction

   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic [3:0] pin_d_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] mode_reg;
   logic [7:0] tl0_reg;
   logic [7:0] th0_reg;
   logic [7:0] tl1_reg;
   logic [7:0] th1_reg;
   logic [3:0] stat_reg;
   logic [3:0] en_reg;
   logic flag0_reg;
   logic flag1_reg;
   logic ovf0_reg;
   logic ovf1_reg;
   logic irq_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // The first stage feeds only the second; edges are taken from the second stage.
   wire [3:0] pin_raw = {count_input_one, count_input_zero, ext_irq_pin_one, ext_irq_pin_zero};
   wire [3:0] fall = pin_d_reg & ~pin_s2_reg;

   wire setup = psel & ~penable;
   wire acc = psel & penable & pready_reg;
   wire wr = acc & pwrite;
   wire hit_ctrl = paddr == addr_of(dtc_pkg::IDX_CTRL);
   wire hit_mode = paddr == addr_of(dtc_pkg::IDX_MODE);
   wire hit_tl0 = paddr == addr_of(dtc_pkg::IDX_TL0);
   wire hit_th0 = paddr == addr_of(dtc_pkg::IDX_TH0);
   wire hit_tl1 = paddr == addr_of(dtc_pkg::IDX_TL1);
   wire hit_th1 = paddr == addr_of(dtc_pkg::IDX_TH1);
   wire hit_stat = paddr == addr_of(dtc_pkg::IDX_STAT);
   wire hit_clr = paddr == addr_of(dtc_pkg::IDX_CLR);
   wire hit_en = paddr == addr_of(dtc_pkg::IDX_EN);
   wire mapped = hit_ctrl | hit_mode | hit_tl0 | hit_th0 | hit_tl1 | hit_th1 | hit_stat | hit_clr | hit_en;
   wire wr_ctrl = wr & hit_ctrl;
   wire wr_mode = wr & hit_mode;
   wire wr_tl0 = wr & hit_tl0;
   wire wr_th0 = wr & hit_th0;
   wire wr_tl1 = wr & hit_tl1;
   wire wr_th1 = wr & hit_th1;
   wire wr_clr = wr & hit_clr;
   wire wr_en = wr & hit_en;

   wire run0 = ctrl_reg[dtc_pkg::CTRL_RUN0];
   wire run1 = ctrl_reg[dtc_pkg::CTRL_RUN1];
   wire type0 = ctrl_reg[dtc_pkg::CTRL_TYPE0];
   wire type1 = ctrl_reg[dtc_pkg::CTRL_TYPE1];
   wire [1:0] m0 = mode_reg[dtc_pkg::MODE_M0_HI:dtc_pkg::MODE_M0_LO];
   wire [1:0] m1 = mode_reg[dtc_pkg::MODE_M1_HI:dtc_pkg::MODE_M1_LO];
   wire split0 = m0 == dtc_pkg::MODE_SPLIT;

   wire en0 = cnt_en(run0, mode_reg[dtc_pkg::MODE_GATE0], pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO],
                     mode_reg[dtc_pkg::MODE_SRC0], fall[dtc_pkg::PIN_CNT0]);
   wire en1_raw = cnt_en(run1, mode_reg[dtc_pkg::MODE_GATE1], pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ONE],
                         mode_reg[dtc_pkg::MODE_SRC1], fall[dtc_pkg::PIN_CNT1]);
   wire en1 = en1_raw & (m1 != dtc_pkg::MODE_SPLIT);

   wire [16:0] t0_step = step(m0, tl0_reg, th0_reg, en0);
   wire [16:0] t1_step = step(m1, tl1_reg, th1_reg, en1);
   // In split mode the high byte of timer zero is a plain timer run by the timer one run bit.
   wire th0_split_ovf = split0 & run1 & (th0_reg == 8'hFF);
   wire [7:0] th0_split = run1 ? th0_reg + 8'h01 : th0_reg;

   // Timer one overflow is not flagged while timer zero is split, since its flag is borrowed.
   wire ovf0_evt = t0_step[16];
   wire ovf1_evt = split0 ? th0_split_ovf : t1_step[16];

   wire [7:0] tl0_next = wr_tl0 ? pwdata[7:0] : t0_step[7:0];
   wire [7:0] th0_next = wr_th0 ? pwdata[7:0] : (split0 ? th0_split : t0_step[15:8]);
   wire [7:0] tl1_next = wr_tl1 ? pwdata[7:0] : t1_step[7:0];
   wire [7:0] th1_next = wr_th1 ? pwdata[7:0] : t1_step[15:8];

   wire [3:0] clr_mask = wr_clr ? pwdata[3:0] : 4'h0;
   wire ext0_evt = type0 ? fall[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO] : ~pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO];
   wire ext1_evt = type1 ? fall[dtc_pkg::PIN_EXT_IRQ_PIN_ONE] : ~pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ONE];
   wire [3:0] evt = {ext1_evt, ext0_evt, ovf1_evt, ovf0_evt};
   // A new event beats a clear in the same cycle.
   wire [3:0] stat_next = (stat_reg & ~clr_mask) | evt;
   wire [3:0] en_next = wr_en ? pwdata[3:0] : en_reg;

   // Edge mode: set wins over the vectoring acknowledge; level mode: follow the inverted pin.
   wire flag0_next = type0 ? (fall[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO] | (flag0_reg & ~irq_ack_zero))
                           : ~pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO];
   wire flag1_next = type1 ? (fall[dtc_pkg::PIN_EXT_IRQ_PIN_ONE] | (flag1_reg & ~irq_ack_one))
                           : ~pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ONE];

   wire [7:0] ctrl_rd = {stat_reg[dtc_pkg::STAT_OVF1], run1, stat_reg[dtc_pkg::STAT_OVF0], run0,
                         flag1_reg, type1, flag0_reg, type0};
   wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                        hit_mode ? mode_reg :
                        hit_tl0 ? tl0_reg :
                        hit_th0 ? th0_reg :
                        hit_tl1 ? tl1_reg :
                        hit_th1 ? th1_reg :
                        hit_stat ? {4'h0, stat_reg} :
                        hit_en ? {4'h0, en_reg} : dtc_pkg::RST_BYTE;
   wire [7:0] ctrl_next = wr_ctrl ? (pwdata[7:0] & dtc_pkg::CTRL_WMASK) : ctrl_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_s1_reg <= dtc_pkg::RST_PINS;
         pin_s2_reg <= dtc_pkg::RST_PINS;
         pin_d_reg <= dtc_pkg::RST_PINS;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_d_reg <= pin_s2_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_reg <= dtc_pkg::RST_BYTE;
         mode_reg <= dtc_pkg::RST_BYTE;
      end else begin
         ctrl_reg <= ctrl_next;
         mode_reg <= wr_mode ? pwdata[7:0] : mode_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tl0_reg <= dtc_pkg::RST_BYTE;
         th0_reg <= dtc_pkg::RST_BYTE;
         tl1_reg <= dtc_pkg::RST_BYTE;
         th1_reg <= dtc_pkg::RST_BYTE;
      end else begin
         tl0_reg <= tl0_next;
         th0_reg <= th0_next;
         tl1_reg <= tl1_next;
         th1_reg <= th1_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stat_reg <= dtc_pkg::RST_STAT;
         en_reg <= dtc_pkg::RST_STAT;
         irq_reg <= 1'b0;
         flag0_reg <= 1'b0;
         flag1_reg <= 1'b0;
         ovf0_reg <= 1'b0;
         ovf1_reg <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         en_reg <= en_next;
         irq_reg <= |(stat_next & en_next);
         flag0_reg <= flag0_next;
         flag1_reg <= flag1_next;
         ovf0_reg <= ovf0_evt;
         ovf1_reg <= ovf1_evt;
      end
   end

   // The answer is registered in the setup cycle so that every bus output comes from a flip-flop; this costs no wait state.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata_reg <= dtc_pkg::RST_WORD;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= setup ? {24'h000000, rd_byte} : prdata_reg;
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign ext_irq_zero_flag = flag0_reg;
   assign ext_irq_one_flag = flag1_reg;
   assign ovf_pulse_zero = ovf0_reg;
   assign ovf_pulse_one = ovf1_reg;

   wire [15:0] cnt0 = {th0_reg, tl0_reg};
   wire [15:0] cnt1 = {th1_reg, tl1_reg};
   wire wr_t0 = wr_tl0 | wr_th0;
   wire wr_t1 = wr_tl1 | wr_th1;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_run0_stop;
      (!run0 && !wr_tl0) |=> $stable(tl0_reg);
   endproperty
   a_run0_stop: assert property (p_run0_stop) else $error("timer zero low byte moved while stopped");

   property p_ext1_level;
      (!type1 && !wr_ctrl) |=> (ext_irq_one_flag == !$past(pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ONE]));
   endproperty
   a_ext1_level: assert property (p_ext1_level) else $error("level flag one not tracking pin");

   property p_ext1_edge;
      (type1 && !wr_ctrl && fall[dtc_pkg::PIN_EXT_IRQ_PIN_ONE]) |=> ext_irq_one_flag;
   endproperty
   a_ext1_edge: assert property (p_ext1_edge) else $error("edge flag one not set");

   property p_ext0_ack;
      (type0 && !wr_ctrl && irq_ack_zero && !fall[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO]) |=> !ext_irq_zero_flag;
   endproperty
   a_ext0_ack: assert property (p_ext0_ack) else $error("edge flag zero not cleared by acknowledge");

   property p_gate1;
      (mode_reg[dtc_pkg::MODE_GATE1] && !pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ONE] && !wr_t1) |=> $stable(cnt1);
   endproperty
   a_gate1: assert property (p_gate1) else $error("timer one counted with gate pin low");

   property p_gate0;
      (mode_reg[dtc_pkg::MODE_GATE0] && !pin_s2_reg[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO] && !wr_tl0) |=> $stable(tl0_reg);
   endproperty
   a_gate0: assert property (p_gate0) else $error("timer zero counted with gate pin low");

   property p_src0;
      (mode_reg[dtc_pkg::MODE_SRC0] && !fall[dtc_pkg::PIN_CNT0] && !wr_tl0) |=> $stable(tl0_reg);
   endproperty
   a_src0: assert property (p_src0) else $error("counter zero moved without an input edge");

   property p_pre13;
      (en0 && m0 == dtc_pkg::MODE_13BIT && tl0_reg[4:0] == dtc_pkg::PRESCALE_TOP && !wr_t0)
         |=> (th0_reg == $past(th0_reg) + 8'h01) && (tl0_reg[4:0] == 5'h00);
   endproperty
   a_pre13: assert property (p_pre13) else $error("prescaler carry missed in thirteen-bit mode");

   property p_inc16;
      (en0 && m0 == dtc_pkg::MODE_16BIT && !wr_t0) |=> cnt0 == $past(cnt0) + 16'h0001;
   endproperty
   a_inc16: assert property (p_inc16) else $error("sixteen-bit count did not advance by one");

   property p_reload;
      (en0 && m0 == dtc_pkg::MODE_RELOAD && tl0_reg == 8'hFF && !wr_t0) |=> tl0_reg == $past(th0_reg);
   endproperty
   a_reload: assert property (p_reload) else $error("auto reload value not loaded");

   property p_split_hi;
      (split0 && run1 && !wr_th0) |=> th0_reg == $past(th0_reg) + 8'h01;
   endproperty
   a_split_hi: assert property (p_split_hi) else $error("split high byte not run by timer one run bit");

   property p_ovf1;
      (en1 && !split0 && m1 == dtc_pkg::MODE_16BIT && cnt1 == 16'hFFFF && !wr_clr)
         |=> stat_reg[dtc_pkg::STAT_OVF1] && ovf_pulse_one ##1 !ovf_pulse_one || en1;
   endproperty
   a_ovf1: assert property (p_ovf1) else $error("timer one overflow not flagged");

   property p_sync;
      ##2 (pin_s2_reg[dtc_pkg::PIN_CNT0] == $past(count_input_zero, 2));
   endproperty
   a_sync: assert property (p_sync) else $error("count input not two stages delayed");

   property p_hold1;
      (m1 == dtc_pkg::MODE_SPLIT && !wr_t1) |=> $stable(cnt1);
   endproperty
   a_hold1: assert property (p_hold1) else $error("timer one moved in mode three");

   property p_irq;
      (|(stat_reg & en_reg)) |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled status bit without interrupt");

   c_ovf0: cover property (ovf_pulse_zero);
   c_reload: cover property (en0 && m0 == dtc_pkg::MODE_RELOAD && tl0_reg == 8'hFF);
   c_edge0: cover property (type0 && fall[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO] ##1 ext_irq_zero_flag);
   c_err: cover property (pslverr && pready);
endmodule

//--- dtc_pins.sv
// Pin side model: interrupt pins, counter inputs and vectoring acknowledges.
// Assumes the bench calls its tasks; idle pins rest high as pulled-up lines do.
`timescale 1ns/1ps
module dtc_pins (
   input wire logic mclk,
   output logic [3:0] pins,
   output logic [1:0] ack
);
   initial begin
      pins = 4'hF;
      ack = 2'h0;
   end
   // Each level is held five cycles so the synchroniser sees it once.
   task automatic level(input int p, input logic v);
      @(posedge mclk);
      pins[p] <= v;
      repeat (4) @(posedge mclk);
   endtask
   task automatic pulse(input int p, input int n);
      repeat (n) begin
         level(p, 1'b0);
         level(p, 1'b1);
      end
   endtask
   task automatic vector(input int i);
      @(posedge mclk);
      ack[i] <= 1'b1;
      @(posedge mclk);
      ack[i] <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
endmodule

//--- dtc_top_test.sv
// Self-checking bench for the dual timer and external interrupt block.
// Assumes dtc_pins drives the pin side and this module is the APB master.
`timescale 1ns/1ps
module dtc_top_test;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pins;
   logic [1:0] ack, flags, ovf;
   int compares = 0;
   int miscompares = 0;
   int cycles = 0;
   int ovf_zero_cnt = 0;
   int ovf_one_cnt = 0;
   dtc_pins u_pins (.mclk(mclk), .pins(pins), .ack(ack));
   dtc_top u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq_pin_zero(pins[dtc_pkg::PIN_EXT_IRQ_PIN_ZERO]), .ext_irq_pin_one(pins[dtc_pkg::PIN_EXT_IRQ_PIN_ONE]),
      .count_input_zero(pins[dtc_pkg::PIN_CNT0]), .count_input_one(pins[dtc_pkg::PIN_CNT1]),
      .irq_ack_zero(ack[0]), .irq_ack_one(ack[1]), .ext_irq_zero_flag(flags[0]),
      .ext_irq_one_flag(flags[1]), .ovf_pulse_zero(ovf[0]), .ovf_pulse_one(ovf[1]), .irq(irq));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic finish_test;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // The ceiling is more than twenty times the expected run so slow answers still finish.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   // Overflow outputs stand for one cycle only, so every pulse is counted as it passes.
   always @(posedge mclk) begin
      if (ovf[0] === 1'b1) ovf_zero_cnt++;
      if (ovf[1] === 1'b1) ovf_one_cnt++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [11:0] adr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction
   // The request stands until the edge at which pready is seen high; the answer is taken at that same edge.
   // No wait-state count is assumed; only the bench timeout ends a hung wait.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, adr(idx), d);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, adr(idx), 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic test_regs;
      for (int k = 0; k < 6; k++) rdc(dtc_pkg::IDX_CTRL + 8'(k), dtc_pkg::RST_WORD);
      chk1(err, 1'b0);
      rdc(dtc_pkg::IDX_STAT, dtc_pkg::RST_WORD);
      rdc(dtc_pkg::IDX_EN, dtc_pkg::RST_WORD);
      rdc(dtc_pkg::IDX_CLR, dtc_pkg::RST_WORD);
      chk1(irq, 1'b0);
      apb(1'b0, 12'h300, 32'h0000_00FF);
      chk(rd, 32'h0000_0000);
      chk1(err, 1'b1);
      wr(dtc_pkg::IDX_STAT, 32'h0000_000F);
      rdc(dtc_pkg::IDX_STAT, 32'h0000_0000);
      wr(dtc_pkg::IDX_MODE, 32'h0000_00A5);
      rdc(dtc_pkg::IDX_MODE, 32'h0000_00A5);
      wr(dtc_pkg::IDX_CTRL, 32'h0000_00FF);
      rdc(dtc_pkg::IDX_CTRL, 32'h0000_0055);
      wr(dtc_pkg::IDX_CTRL, 32'h0000_0000);
      $display("register test done");
   endtask
   task automatic test_modes;
      logic [7:0] tab [3][4];
      int n0;
      tab = '{'{8'hFE, 8'hFF, 8'hE0, 8'h00}, '{8'hFE, 8'hFF, 8'h00, 8'h00}, '{8'hFE, 8'hA5, 8'hA5, 8'hA5}};
      for (int m = 0; m < 3; m++) begin
         wr(dtc_pkg::IDX_MODE, 32'h0000_0004 | 32'(m));
         wr(dtc_pkg::IDX_TL0, 32'(tab[m][0]));
         wr(dtc_pkg::IDX_TH0, 32'(tab[m][1]));
         wr(dtc_pkg::IDX_CLR, 32'h0000_000F);
         n0 = ovf_zero_cnt;
         wr(dtc_pkg::IDX_CTRL, 32'h0000_0010);
         u_pins.pulse(2, 2);
         wr(dtc_pkg::IDX_CTRL, 32'h0000_0000);
         u_pins.pulse(2, 1);
         rdc(dtc_pkg::IDX_TL0, 32'(tab[m][2]));
         rdc(dtc_pkg::IDX_TH0, 32'(tab[m][3]));
         rdc(dtc_pkg::IDX_STAT, 32'h0000_0001);
         chk(32'(ovf_zero_cnt - n0), 32'h0000_0001);
      end
      $display("mode test done");
   endtask
   task automatic test_count;
      for (int i = 0; i < 2; i++) begin
         wr(dtc_pkg::IDX_MODE, 32'h0000_000D << (4 * i));
         wr(dtc_pkg::IDX_TL0 + 8'(i), 32'h0000_0000);
         wr(dtc_pkg::IDX_CTRL, 32'h0000_0010 << (2 * i));
         u_pins.pulse(2 + i, 2);
         u_pins.level(i, 1'b0);
         u_pins.pulse(2 + i, 2);
         u_pins.level(i, 1'b1);
         wr(dtc_pkg::IDX_CTRL, 32'h0000_0000);
         u_pins.pulse(2 + i, 1);
         rdc(dtc_pkg::IDX_TL0 + 8'(i), 32'h0000_0002);
      end
      wr(dtc_pkg::IDX_MODE, 32'h0000_0070);
      wr(dtc_pkg::IDX_CTRL, 32'h0000_0040);
      u_pins.pulse(3, 2);
      wr(dtc_pkg::IDX_CTRL, 32'h0000_0000);
      rdc(dtc_pkg::IDX_TL1, 32'h0000_0002);
      $display("count test done");
   endtask
   task automatic test_split;
      int n1;
      // Timer one wraps once in sixteen-bit mode on the internal clock before split mode is tried.
      wr(dtc_pkg::IDX_MODE, 32'h0000_0010);
      wr(dtc_pkg::IDX_TL1, 32'h0000_00FE);
      wr(dtc_pkg::IDX_TH1, 32'h0000_00FF);
      wr(dtc_pkg::IDX_CLR, 32'h0000_000F);
      n1 = ovf_one_cnt;
      wr(dtc_pkg::IDX_CTRL, 32'h0000_0040);
      wr(dtc_pkg::IDX_CTRL, 32'h0000_0000);
      rdc(dtc_pkg::IDX_STAT, 32'h0000_0002);
      chk(32'(ovf_one_cnt - n1), 32'h0000_0001);
      n1 = ovf_one_cnt;
      wr(dtc_pkg::IDX_MODE, 32'h0000_0007);
      wr(dtc_pkg::IDX_TL0, 32'h0000_0000);
      wr(dtc_pkg::IDX_TH0, 32'h0000_00FF);
      wr(dtc_pkg::IDX_CLR, 32'h0000_000F);
      wr(dtc_pkg::IDX_CTRL, 32'h0000_0050);
      u_pins.pulse(2, 1);
      wr(dtc_pkg::IDX_CTRL, 32'h0000_0000);
      rdc(dtc_pkg::IDX_TL0, 32'h0000_0001);
      rdc(dtc_pkg::IDX_STAT, 32'h0000_0002);
      rdc(dtc_pkg::IDX_CTRL, 32'h0000_0080);
      chk(32'(ovf_one_cnt - n1), 32'h0000_0001);
      $display("split test done");
   endtask
   task automatic test_irq;
      for (int i = 0; i < 2; i++) begin
         wr(dtc_pkg::IDX_CLR, 32'h0000_000F);
         wr(dtc_pkg::IDX_EN, 32'h0000_0004 << i);
         wr(dtc_pkg::IDX_CTRL, 32'h0000_0001 << (2 * i));
         u_pins.level(i, 1'b0);
         u_pins.level(i, 1'b1);
         chk1(flags[i], 1'b1);
         chk1(irq, 1'b1);
         rdc(dtc_pkg::IDX_CTRL, 32'h0000_0003 << (2 * i));
         u_pins.vector(i);
         chk1(flags[i], 1'b0);
         chk1(irq, 1'b1);
         wr(dtc_pkg::IDX_CLR, 32'h0000_0004 << i);
         @(negedge mclk);
         chk1(irq, 1'b0);
         wr(dtc_pkg::IDX_EN, 32'h0000_0000);
         u_pins.pulse(i, 1);
         chk1(irq, 1'b0);
         rdc(dtc_pkg::IDX_STAT, 32'h0000_0004 << i);
         u_pins.vector(i);
         wr(dtc_pkg::IDX_CTRL, 32'h0000_0000);
         u_pins.level(i, 1'b0);
         chk1(flags[i], 1'b1);
         u_pins.level(i, 1'b1);
         chk1(flags[i], 1'b0);
      end
      $display("interrupt test done");
   endtask
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      test_regs();
      test_modes();
      test_count();
      test_split();
      test_irq();
      finish_test();
   end
endmodule
